// file: common/edas_phase_if.sv
// interface: machine cycle phase signals between sequencer and access engine
`timescale 1ns/1ps
`default_nettype none
interface edas_phase_if;
  logic c1;
  logic c4;
  logic hold;
  modport seq (output c1, output c4, input hold);
  modport eng (input c1, input c4, output hold);
endinterface
`default_nettype wire

// file: common/edas_pkg.sv
// package: offsets, fields, reset values and timing for the external data access stretch block
package edas_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] EDAS_PTR_SEL_ADDR = 8'h86;
  localparam logic [7:0] EDAS_CLK_CTRL_ADDR = 8'h8E;
  localparam int EDAS_SEL_BIT_POS = 0;
  localparam int EDAS_STRETCH_LSB = 0;
  localparam int EDAS_STRETCH_W = 3;
  localparam logic [2:0] EDAS_STRETCH_RESET = 3'h1;
  localparam logic [7:0] EDAS_CLK_CTRL_RESET = 8'h01;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int EDAS_CLK_PER_MC = 4;
  localparam int EDAS_FAST_STROBE_CLKS = 2;
  localparam int EDAS_BASE_MC = 2;

  typedef enum logic [3:0] {
    EDAS_ST_C1 = 4'h1,
    EDAS_ST_C2 = 4'h2,
    EDAS_ST_C3 = 4'h4,
    EDAS_ST_C4 = 4'h8
  } edas_phase_type;

  typedef enum logic [2:0] {
    EDAS_AC_IDLE = 3'h1,
    EDAS_AC_FETCH = 3'h2,
    EDAS_AC_ACCESS = 3'h4
  } edas_acc_type;

  // strobe width in clocks for a stretch setting
  function automatic logic [4:0] edas_strobe_clks(input logic [2:0] s);
    edas_strobe_clks = (s == 3'h0) ? 5'(EDAS_FAST_STROBE_CLKS) : {s, 2'b00};
  endfunction
endpackage

// file: rtl/edas_phase_seq.sv
// module: four-state machine cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module edas_phase_seq
  import edas_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  edas_phase_if.seq ph
);
  edas_phase_type phase_reg;

  // phases run in fixed order, always four clocks per machine cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg <= EDAS_ST_C1;
    end else begin
      unique case (phase_reg)
        EDAS_ST_C1: phase_reg <= EDAS_ST_C2;
        EDAS_ST_C2: phase_reg <= EDAS_ST_C3;
        EDAS_ST_C3: phase_reg <= EDAS_ST_C4;
        EDAS_ST_C4: phase_reg <= EDAS_ST_C1;
        default: phase_reg <= EDAS_ST_C1;
      endcase
    end
  end

  assign ph.c1 = (phase_reg == EDAS_ST_C1);
  assign ph.c4 = (phase_reg == EDAS_ST_C4);

  chk_phase_order: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ph.c1 |-> ##3 ph.c4 ##1 ph.c1)
    else $error("machine cycle is not four clocks");
endmodule // edas_phase_seq
`default_nettype wire

// file: rtl/edas_top.sv
// module: external data access cycle with address forming and programmable strobe stretch
// ----------------------------------------------------------------
// Overview of operation
// - register-indirect form: low byte from bank register, high byte from port 2 latch
// - pointer form: full 16-bit address from the selected data pointer
// - two data pointers, chosen by bit 0 of the selector register at 86h
// - other selector bits have no effect and read as zero
// - selector 0 picks primary pointer, 1 picks secondary; incrementing toggles
// - access starts with a four-clock fetch cycle, address driven next cycle
// - stretch is a three-bit field in bits 2-0 of clock control
// - access lasts stretch plus two machine cycles
// - stretch lengthens only external accesses, other instructions unaffected
// - stretch resets to 1, giving three machine cycles
// - strobe lasts 2 clocks at stretch 0, else four times stretch clocks
// - each machine cycle is four clocks, phases in fixed order
// - read and write strobes lengthen in proportion to stretch for stretch 1 and above
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module edas_top
  import edas_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  // special function register port
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // core side
  input wire logic start_i,
  input wire logic use_pointer_i,
  input wire logic is_write_i,
  input wire logic [7:0] bank_index_register_i,
  input wire logic [7:0] port2_latch_i,
  input wire logic [15:0] primary_data_pointer_i,
  input wire logic [15:0] secondary_data_pointer_i,
  input wire logic [7:0] wdata_i,
  output logic busy_o,
  output logic done_o,
  output logic core_hold_o,
  output logic pointer_select_bit_o,
  // external memory side
  output logic [15:0] ext_addr_o,
  output logic [7:0] ext_wdata_o,
  output logic ext_data_oe_n_o,
  output logic ext_rd_n_o,
  output logic ext_wr_n_o
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1_reg;
  logic rst_n;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  edas_phase_if ph ();
  edas_phase_seq u_seq (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .ph(ph)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic pointer_select_bit_reg;
  logic [2:0] stretch_field_reg;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pointer_select_bit_reg <= 1'b0;
    end else if (sfr_wr_i && sfr_addr_i == EDAS_PTR_SEL_ADDR) begin
      pointer_select_bit_reg <= sfr_wdata_i[EDAS_SEL_BIT_POS];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stretch_field_reg <= EDAS_STRETCH_RESET;
    end else if (sfr_wr_i && sfr_addr_i == EDAS_CLK_CTRL_ADDR) begin
      stretch_field_reg <= sfr_wdata_i[EDAS_STRETCH_LSB +: EDAS_STRETCH_W];
    end
  end

  // upper selector bits are not stored, so they read zero
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata_o <= 8'h00;
    end else begin
      unique case (sfr_addr_i)
        EDAS_PTR_SEL_ADDR: sfr_rdata_o <= {7'h00, pointer_select_bit_reg};
        EDAS_CLK_CTRL_ADDR: sfr_rdata_o <= {5'h00, stretch_field_reg};
        default: sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pointer_select_bit_o <= 1'b0;
    end else begin
      pointer_select_bit_o <= pointer_select_bit_reg;
    end
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  edas_acc_type acc_reg;
  logic [3:0] mc_left_reg;
  logic [4:0] strobe_left_reg;
  logic [2:0] acc_stretch_reg;
  logic is_write_reg;
  logic [15:0] addr_reg;
  logic [7:0] wdata_reg;

  // request is taken only at a machine cycle boundary so it aligns with a fetch
  wire take = start_i && (acc_reg == EDAS_AC_IDLE) && ph.c4;
  wire [15:0] sel_ptr = pointer_select_bit_reg ? secondary_data_pointer_i : primary_data_pointer_i;
  wire [15:0] next_addr = use_pointer_i ? sel_ptr : {port2_latch_i, bank_index_register_i};

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= EDAS_AC_IDLE;
      mc_left_reg <= 4'h0;
      acc_stretch_reg <= 3'h0;
      is_write_reg <= 1'b0;
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
    end else begin
      unique case (acc_reg)
        EDAS_AC_IDLE: begin
          if (take) begin
            acc_reg <= EDAS_AC_FETCH;
            acc_stretch_reg <= stretch_field_reg;
            is_write_reg <= is_write_i;
            addr_reg <= next_addr;
            wdata_reg <= wdata_i;
            mc_left_reg <= 4'({1'b0, stretch_field_reg} + 4'(EDAS_BASE_MC - 1));
          end
        end
        EDAS_AC_FETCH: begin
          if (ph.c4) begin
            acc_reg <= EDAS_AC_ACCESS;
          end
        end
        EDAS_AC_ACCESS: begin
          if (ph.c4) begin
            mc_left_reg <= mc_left_reg - 4'h1;
            if (mc_left_reg == 4'h1) begin
              acc_reg <= EDAS_AC_IDLE;
            end
          end
        end
        default: acc_reg <= EDAS_AC_IDLE;
      endcase
    end
  end

  // strobe starts at the second clock of the first access cycle at stretch 0,
  // otherwise at its first clock; a down counter sets the width
  wire access_first = (acc_reg == EDAS_AC_ACCESS)
    && (mc_left_reg == 4'({1'b0, acc_stretch_reg} + 4'(EDAS_BASE_MC - 1)));
  wire strobe_start = (acc_reg == EDAS_AC_FETCH && ph.c4 && acc_stretch_reg != 3'h0)
    || (access_first && ph.c1 && acc_stretch_reg == 3'h0);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strobe_left_reg <= 5'h00;
    end else if (strobe_start) begin
      strobe_left_reg <= edas_strobe_clks(acc_stretch_reg);
    end else if (strobe_left_reg != 5'h00) begin
      strobe_left_reg <= strobe_left_reg - 5'h01;
    end
  end

  wire strobe_next = strobe_start || (strobe_left_reg > 5'h01);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_rd_n_o <= 1'b1;
      ext_wr_n_o <= 1'b1;
      ext_data_oe_n_o <= 1'b1;
      ext_addr_o <= 16'h0000;
      ext_wdata_o <= 8'h00;
    end else begin
      ext_rd_n_o <= !(strobe_next && !is_write_reg);
      ext_wr_n_o <= !(strobe_next && is_write_reg);
      ext_data_oe_n_o <= !(acc_reg == EDAS_AC_ACCESS && is_write_reg);
      // address held from fetch end through the access, steady under strobe
      if (acc_reg == EDAS_AC_FETCH && ph.c4) begin
        ext_addr_o <= addr_reg;
        ext_wdata_o <= wdata_reg;
      end
    end
  end

  // core is held only while an external access is stretched
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      core_hold_o <= 1'b0;
    end else begin
      busy_o <= (acc_reg != EDAS_AC_IDLE) || take;
      done_o <= (acc_reg == EDAS_AC_ACCESS) && ph.c4 && (mc_left_reg == 4'h1);
      core_hold_o <= (acc_reg == EDAS_AC_ACCESS) && (mc_left_reg > 4'h1);
    end
  end
  assign ph.hold = core_hold_o;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_rd_low;
    !ext_rd_n_o;
  endsequence

  chk_one_strobe: assert property (@(posedge clk_i) disable iff (!rst_n)
    !(!ext_rd_n_o && !ext_wr_n_o))
    else $error("both strobes active");
  chk_addr_stable: assert property (@(posedge clk_i) disable iff (!rst_n)
    (!ext_rd_n_o || !ext_wr_n_o) && $past(!ext_rd_n_o || !ext_wr_n_o) |-> $stable(ext_addr_o))
    else $error("address moved under strobe");
  chk_rd_width_s0: assert property (@(posedge clk_i) disable iff (!rst_n)
    $fell(ext_rd_n_o) && acc_stretch_reg == 3'h0 |-> s_rd_low [*2] ##1 ext_rd_n_o)
    else $error("stretch 0 strobe not two clocks");
  chk_rd_width_s1: assert property (@(posedge clk_i) disable iff (!rst_n)
    $fell(ext_rd_n_o) && acc_stretch_reg == 3'h1 |-> s_rd_low [*4] ##1 ext_rd_n_o)
    else $error("stretch 1 strobe not four clocks");
  chk_wr_width_s2: assert property (@(posedge clk_i) disable iff (!rst_n)
    $fell(ext_wr_n_o) && acc_stretch_reg == 3'h2 |-> !ext_wr_n_o [*8] ##1 ext_wr_n_o)
    else $error("stretch 2 strobe not eight clocks");
  chk_len_default: assert property (@(posedge clk_i) disable iff (!rst_n)
    take && stretch_field_reg == 3'h1 |-> ##13 done_o)
    else $error("default access not three machine cycles");
  chk_len_fast: assert property (@(posedge clk_i) disable iff (!rst_n)
    take && stretch_field_reg == 3'h0 |-> ##9 done_o)
    else $error("fast access not two machine cycles");
  chk_sel_read: assert property (@(posedge clk_i) disable iff (!rst_n)
    sfr_wr_i && sfr_addr_i == EDAS_PTR_SEL_ADDR && !$past(sfr_wr_i) ##1 sfr_addr_i == EDAS_PTR_SEL_ADDR
    |=> sfr_rdata_o[7:1] == 7'h00)
    else $error("selector upper bits not zero");
  chk_ptr_addr: assert property (@(posedge clk_i) disable iff (!rst_n)
    take && use_pointer_i && !pointer_select_bit_reg |-> ##5 ext_addr_o == $past(primary_data_pointer_i, 5))
    else $error("pointer address wrong");
  chk_idx_addr: assert property (@(posedge clk_i) disable iff (!rst_n)
    take && !use_pointer_i |-> ##5 ext_addr_o[15:8] == $past(port2_latch_i, 5))
    else $error("indexed high byte wrong");
  chk_no_hold_idle: assert property (@(posedge clk_i) disable iff (!rst_n)
    acc_reg == EDAS_AC_IDLE && !take |=> !core_hold_o)
    else $error("core held outside access");

  // ----------------------------------------------------------------
  // check helpers
  // ----------------------------------------------------------------
  // widths up to 28 clocks are counted, a repetition that long is too costly to unroll
  logic [4:0] strobe_run_reg;
  logic [4:0] hold_run_reg;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strobe_run_reg <= 5'h00;
    end else if (!ext_rd_n_o || !ext_wr_n_o) begin
      strobe_run_reg <= strobe_run_reg + 5'h01;
    end else begin
      strobe_run_reg <= 5'h00;
    end
  end

  // cleared at each take so the count belongs to one access only
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_run_reg <= 5'h00;
    end else if (take) begin
      hold_run_reg <= 5'h00;
    end else if (core_hold_o) begin
      hold_run_reg <= hold_run_reg + 5'h01;
    end
  end

  chk_strobe_width: assert property (@(posedge clk_i) disable iff (!rst_n)
    ext_rd_n_o && ext_wr_n_o && strobe_run_reg != 5'h00
    |-> strobe_run_reg == ((acc_stretch_reg == 3'h0) ? 5'(EDAS_FAST_STROBE_CLKS)
      : 5'(EDAS_CLK_PER_MC * acc_stretch_reg)))
    else $error("strobe width wrong for stretch");
  chk_hold_len: assert property (@(posedge clk_i) disable iff (!rst_n)
    done_o |-> hold_run_reg == 5'(EDAS_CLK_PER_MC * acc_stretch_reg))
    else $error("core hold not the stretched cycles");
  chk_sec_addr: assert property (@(posedge clk_i) disable iff (!rst_n)
    take && use_pointer_i && pointer_select_bit_reg |-> ##5 ext_addr_o == $past(secondary_data_pointer_i, 5))
    else $error("secondary pointer address wrong");
  chk_idx_low: assert property (@(posedge clk_i) disable iff (!rst_n)
    take && !use_pointer_i |-> ##5 ext_addr_o[7:0] == $past(bank_index_register_i, 5))
    else $error("indexed low byte wrong");
  chk_rd_no_drive: assert property (@(posedge clk_i) disable iff (!rst_n)
    !ext_rd_n_o |-> ext_data_oe_n_o)
    else $error("data driven during read");
  chk_done_busy: assert property (@(posedge clk_i) disable iff (!rst_n)
    done_o |-> busy_o)
    else $error("done outside busy");
endmodule // edas_top
`default_nettype wire

// file: testbench/edas_ext_mem.sv
// external memory model: measures strobes and captures each access
`timescale 1ns/1ps
`default_nettype none
module edas_ext_mem (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  output logic [4:0] width_o,
  output logic [15:0] addr_o,
  output logic [7:0] data_o,
  output logic wr_seen_o,
  output logic bad_o
);
  logic [4:0] run_reg;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_reg <= 5'h00;
      width_o <= 5'h00;
      addr_o <= 16'h0000;
      data_o <= 8'h00;
      wr_seen_o <= 1'b0;
      bad_o <= 1'b0;
    end else if (!rd_n_i || !wr_n_i) begin
      run_reg <= run_reg + 5'h01;
      addr_o <= addr_i;
      wr_seen_o <= !wr_n_i;
      // write completes inside the strobe window
      if (!wr_n_i) data_o <= wdata_i;
      if (!rd_n_i && !wr_n_i) bad_o <= 1'b1;
      if (run_reg != 5'h00 && addr_i !== addr_o) bad_o <= 1'b1;
    end else if (run_reg != 5'h00) begin
      width_o <= run_reg;
      run_reg <= 5'h00;
    end
  end
endmodule // edas_ext_mem
`default_nettype wire

// file: testbench/tb_external_data_access_stretch.sv
// testbench: register access, address forming and stretched strobes
`timescale 1ns/1ps
`default_nettype none
module tb_external_data_access_stretch;
  import edas_pkg::*;
  logic clk_i = 1'b0, reset_n_i = 1'b0, sfr_wr_i = 1'b0, start_i = 1'b0;
  logic use_pointer_i = 1'b0, is_write_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, bank_i = 8'h00, p2_i = 8'h00, wdata_i = 8'h00;
  logic [15:0] dp0_i = 16'h0000, dp1_i = 16'h0000;
  logic [7:0] sfr_rdata_o, ext_wdata_o;
  logic [15:0] ext_addr_o, m_addr;
  logic busy_o, done_o, core_hold_o, sel_o, ext_data_oe_n_o, ext_rd_n_o, ext_wr_n_o, m_wr, m_bad;
  logic [4:0] m_width;
  logic [7:0] m_data, d;
  logic sel = 1'b0;
  int seed = 32'h4cee, n_fail = 0, samples_checked = 0;
  always #25 clk_i = ~clk_i;
  edas_top i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .sfr_wr_i(sfr_wr_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .start_i(start_i), .use_pointer_i(use_pointer_i),
    .is_write_i(is_write_i), .bank_index_register_i(bank_i), .port2_latch_i(p2_i),
    .primary_data_pointer_i(dp0_i), .secondary_data_pointer_i(dp1_i), .wdata_i(wdata_i), .busy_o(busy_o),
    .done_o(done_o), .core_hold_o(core_hold_o), .pointer_select_bit_o(sel_o), .ext_addr_o(ext_addr_o),
    .ext_wdata_o(ext_wdata_o), .ext_data_oe_n_o(ext_data_oe_n_o), .ext_rd_n_o(ext_rd_n_o), .ext_wr_n_o(ext_wr_n_o));
  edas_ext_mem i_mem (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(ext_addr_o), .wdata_i(ext_wdata_o),
    .rd_n_i(ext_rd_n_o), .wr_n_i(ext_wr_n_o), .width_o(m_width), .addr_o(m_addr), .data_o(m_data),
    .wr_seen_o(m_wr), .bad_o(m_bad));
  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] exp_w(input logic [2:0] s);
    exp_w = (s == 3'h0) ? 16'h0002 : 16'(4 * s);
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr_i = a;
    sfr_wdata_i = v;
    sfr_wr_i = 1'b1;
    @(posedge clk_i);
    #1 sfr_wr_i = 1'b0;
  endtask
  task automatic sfr_rd(input logic [7:0] a);
    sfr_addr_i = a;
    @(posedge clk_i);
    #1 d = sfr_rdata_o;
  endtask
  // one access with random form, direction and address; start held until taken
  task automatic acc(input logic [2:0] s);
    int n;
    int hold_n;
    logic [15:0] ea;
    logic oe_seen;
    {use_pointer_i, is_write_i, wdata_i, bank_i, p2_i} = 26'($random(seed));
    dp0_i = 16'($random(seed));
    dp1_i = 16'($random(seed));
    ea = use_pointer_i ? (sel ? dp1_i : dp0_i) : {p2_i, bank_i};
    start_i = 1'b1;
    n = 0;
    oe_seen = 1'b0;
    hold_n = 0;
    while (!busy_o && n < 8) begin
      @(posedge clk_i);
      #1 n++;
    end
    start_i = 1'b0;
    n = 0;
    while (!done_o && n < 60) begin
      @(posedge clk_i);
      #1 n++;
      oe_seen |= !ext_data_oe_n_o;
      hold_n += int'(core_hold_o);
    end
    check(16'(n), 16'((s + 2) * EDAS_CLK_PER_MC));
    check(ext_addr_o, ea);
    check(m_addr, ea);
    check(16'(m_width), exp_w(s));
    check(16'(m_wr), 16'(is_write_i));
    check(16'(oe_seen), 16'(is_write_i));
    check(16'(hold_n), 16'(EDAS_CLK_PER_MC * s));
    check(16'(m_bad), 16'h0000);
    if (is_write_i) check(16'(m_data), 16'(wdata_i));
    @(posedge clk_i);
    #1 check(16'(core_hold_o), 16'h0000);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [2:0] st;
    repeat (10) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 sfr_rd(EDAS_PTR_SEL_ADDR);
    check(16'(d), 16'h0000);
    sfr_rd(EDAS_CLK_CTRL_ADDR);
    check(16'(d), 16'(EDAS_CLK_CTRL_RESET));
    acc(EDAS_STRETCH_RESET);
    sfr_wr(EDAS_PTR_SEL_ADDR, 8'hFF);
    sel = 1'b1;
    sfr_rd(EDAS_PTR_SEL_ADDR);
    check(16'(d), 16'h0001);
    for (int i = 0; i < 20; i++) begin
      st = (i < 8) ? i[2:0] : 3'($random(seed));
      sfr_wr(EDAS_CLK_CTRL_ADDR, {5'h00, st} | 8'hF8);
      sfr_rd(EDAS_CLK_CTRL_ADDR);
      check(16'(d[2:0]), 16'(st));
      sfr_wr(EDAS_PTR_SEL_ADDR, {7'h00, sel} + 8'h01);
      sel = ~sel;
      // the selector output is a registered copy, one clock behind the write
      @(posedge clk_i);
      #1 check(16'(sel_o), 16'(sel));
      acc(st);
      acc(st);
    end
    sfr_rd(8'h55);
    check(16'(d), 16'h0000);
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    end_of_test;
  end
endmodule // tb_external_data_access_stretch
`default_nettype wire
